// File: verilog/irq_vec_pkg.sv
package irq_vec_pkg;
  // ---------------------------------------------------------------
  // Vector addresses, highest priority first.
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_FLASH = 16'hfffa;
  localparam logic [15:0] VEC_SUSPEND_END = 16'hfff8;
  localparam logic [15:0] VEC_EXT = 16'hfff6;
  localparam logic [15:0] VEC_TIMER = 16'hfff4;
  localparam logic [15:0] VEC_RESERVED = 16'hfff2;
  localparam logic [15:0] VEC_SERIAL = 16'hfff0;
  localparam logic [15:0] VEC_BUS = 16'hffee;
  // ---------------------------------------------------------------
  // Field positions, reset values and counts.
  // ---------------------------------------------------------------
  localparam int MASK_BIT = 3;
  localparam logic [7:0] EDGE_EN_RESET = 8'h00;
  localparam logic [7:0] RISE_LINES = 8'h33;
  localparam logic [7:0] FALL_LINES = 8'hcc;
  localparam int START_DELAY_CYCLES = 4096;
  localparam int CLOCK_NS = 8;
  localparam int PUSH_BYTES = 5;
  localparam logic [2:0] PUSH_LAST = 3'h4;
  // Entry states: stack five bytes, then fetch two vector bytes.
  typedef enum logic [5:0] {
    ST_DELAY = 6'h01,
    ST_RUN = 6'h02,
    ST_STACK = 6'h04,
    ST_VECTOR = 6'h08,
    ST_UNSTACK = 6'h10,
    ST_SLEEP = 6'h20
  } seq_t;
endpackage : irq_vec_pkg

// File: verilog/irq_vec.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Maskable service only while mask clear.
// - Current instruction completes before entry.
// - Entry stacks PC, X, A, CC.
// - Entry sets the mask bit.
// - Then load PC from selected vector.
// - Return pops context, clears mask; the code instead reloads mask from bit 3 of the popped CC.
// - Simultaneous requests use fixed priority.
// - Trap is taken regardless of mask.
// - Any interrupt wakes from wait.
// - Only edge, suspend-end, reset leave halt.
// - Lines 1,2,5,6 sense rising edges.
// - Lines 3,4,7,8 sense falling edges.
// - Line needs its enable bit, mask clear.
// - Peripheral flag needs enable, else pending.
// - Status access then peripheral access clears.
// - Clearing discards the pending latch.
// - Vector map in descending priority order.
// - Reset loads PC from top vector.
// - Wait 4096 cycles after oscillator start.
// - Watchdog reset drives reset pin low.
// - Mask is CC bit 3.
// - Edge enable bits lines 8..1, reset 00h.
module irq_vec
  import irq_vec_pkg::*;
#(
  parameter int DELAY_CYCLES = START_DELAY_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic WATCHDOG_RESET,
  output logic RESET_PIN_OUT_N,
  output logic RESET_PIN_OE_N,
  input wire logic [7:0] EXT_IRQ_PIN,
  input wire logic [7:0] EXT_EDGE_ENABLE_REG,
  input wire logic EXT_EDGE_ENABLE_WR,
  input wire logic INSTR_BOUNDARY,
  input wire logic TRAP_INSTR,
  input wire logic RETURN_FROM_INTERRUPT_INSTR,
  input wire logic WAIT_FOR_IRQ_INSTR,
  input wire logic HALT_INSTR,
  input wire logic SET_MASK,
  input wire logic CLEAR_MASK,
  input wire logic [7:0] CONDITION_CODE_IN,
  input wire logic [15:0] PROGRAM_COUNTER_IN,
  input wire logic [7:0] INDEX_IN,
  input wire logic [7:0] ACCUM_IN,
  input wire logic [7:0] STACK_DATA_IN,
  input wire logic [3:0] PERIPH_FLAG,
  input wire logic [3:0] PERIPH_ENABLE,
  input wire logic [3:0] PERIPH_FLAG_CLEAR,
  output logic [7:0] EXT_EDGE_ENABLE_Q,
  output logic MASK,
  output logic CPU_HOLD,
  output logic STACK_WRITE,
  output logic STACK_READ,
  output logic [7:0] STACK_DATA_OUT,
  output logic [2:0] STACK_INDEX,
  output logic VECTOR_READ,
  output logic [15:0] VECTOR_ADDR,
  output logic PC_LOAD,
  output logic [15:0] PROGRAM_COUNTER_OUT,
  output logic [7:0] RESTORED_CC,
  output logic RESTORE_DONE,
  output logic SLEEPING
);
  // ---------------------------------------------------------------
  // Derived counts.
  // ---------------------------------------------------------------
  localparam int DELAY_NS = DELAY_CYCLES * CLOCK_NS;
  localparam int DELAY_CNT = DELAY_NS / CLOCK_NS;
  localparam logic [12:0] DELAY_LAST = 13'(DELAY_CNT - 1);

  // Source order: 0 flash, 1 suspend end, 2 timer, 3 serial.
  seq_t st_q, st_d;
  logic [12:0] cnt_q, cnt_d;
  logic [7:0] en_q, en_d;
  logic [7:0] pin_q, pin_d;
  logic ext_pend_q, ext_pend_d;
  logic mask_q, mask_d;
  logic halt_q, halt_d;
  logic [2:0] idx_q, idx_d;
  logic [15:0] vec_q, vec_d;
  logic [15:0] pc_q, pc_d;
  logic [39:0] ctx_q, ctx_d;
  logic [7:0] lo_q, lo_d;
  logic [3:0] per_pend_q, per_pend_d;
  logic fresh_q, fresh_d;
  logic [7:0] rise, fall;
  logic [3:0] per_req;
  logic any_req, wake, take, enter;
  logic [15:0] sel_vec;

  // ---------------------------------------------------------------
  // Request detection and priority.
  // ---------------------------------------------------------------
  // Edges are judged against the previous sample; pins count as synchronous.
  always_comb
  begin
    rise = EXT_IRQ_PIN & ~pin_q & RISE_LINES;
    fall = ~EXT_IRQ_PIN & pin_q & FALL_LINES;
    per_req = per_pend_q & PERIPH_ENABLE;
    any_req = ext_pend_q | (|per_req);
    // Halt wakes only on edge lines or suspend end; other sources stay asleep.
    wake = halt_q ? (ext_pend_q | per_req[1]) : any_req;
    sel_vec = TRAP_INSTR ? VEC_TRAP : VEC_FLASH;
    if (!TRAP_INSTR)
    begin
      if (per_req[0])
        sel_vec = VEC_FLASH;
      else if (per_req[1])
        sel_vec = VEC_SUSPEND_END;
      else if (ext_pend_q)
        sel_vec = VEC_EXT;
      else if (per_req[2])
        sel_vec = VEC_TIMER;
      else if (per_req[3])
        sel_vec = VEC_SERIAL;
      else
        sel_vec = VEC_BUS;
    end
    take = TRAP_INSTR | (any_req & ~mask_q);
  end

  // ---------------------------------------------------------------
  // Sequencer.
  // ---------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    en_d = EXT_EDGE_ENABLE_WR ? EXT_EDGE_ENABLE_REG : en_q;
    pin_d = EXT_IRQ_PIN;
    // Enabled lines share one vector and merge into a single request.
    ext_pend_d = ext_pend_q | (|((rise | fall) & en_q));
    // Flags latch while masked; a clear sequence drops the latch, set wins.
    per_pend_d = (per_pend_q & ~PERIPH_FLAG_CLEAR) | PERIPH_FLAG;
    mask_d = mask_q;
    halt_d = halt_q;
    idx_d = idx_q;
    vec_d = vec_q;
    pc_d = pc_q;
    ctx_d = ctx_q;
    lo_d = lo_q;
    fresh_d = 1'b0;
    enter = 1'b0;
    if (SET_MASK)
      mask_d = 1'b1;
    if (CLEAR_MASK)
      mask_d = 1'b0;
    case (st_q)
      ST_DELAY:
      begin
        // Execution held until the start delay has expired.
        if (cnt_q == DELAY_LAST)
        begin
          cnt_d = '0;
          st_d = ST_VECTOR;
          idx_d = '0;
          vec_d = VEC_RESET;
          enter = halt_q; // A halt wake goes on to service its waking source.
          halt_d = 1'b0;
        end
        else
          cnt_d = cnt_q + 13'h0001;
      end
      ST_RUN:
      begin
        // Only at an instruction boundary, so the current one completes.
        if (INSTR_BOUNDARY && RETURN_FROM_INTERRUPT_INSTR)
        begin
          st_d = ST_UNSTACK;
          idx_d = '0;
        end
        else if (INSTR_BOUNDARY && take)
          enter = 1'b1;
        else if (INSTR_BOUNDARY && (WAIT_FOR_IRQ_INSTR || HALT_INSTR))
        begin
          st_d = ST_SLEEP;
          mask_d = 1'b0;
          halt_d = HALT_INSTR;
        end
      end
      ST_STACK:
      begin
        // PCL, PCH, X, A, CC in that order, five bytes.
        ctx_d = {ctx_q[31:0], 8'h00};
        idx_d = idx_q + 3'h1;
        if (idx_q == PUSH_LAST)
        begin
          mask_d = 1'b1;
          st_d = ST_VECTOR;
          idx_d = '0;
        end
      end
      ST_VECTOR:
      begin
        // Two vector bytes, high then low, then jump.
        idx_d = idx_q + 3'h1;
        if (idx_q == 3'h0)
          lo_d = STACK_DATA_IN;
        else
        begin
          pc_d = {lo_q, STACK_DATA_IN};
          st_d = ST_RUN;
        end
      end
      ST_UNSTACK:
      begin
        // Pops CC first; the mask is reloaded from bit 3 of the restored CC.
        ctx_d = {ctx_q[31:0], STACK_DATA_IN};
        idx_d = idx_q + 3'h1;
        if (idx_q == 3'h0)
          mask_d = STACK_DATA_IN[MASK_BIT];
        if (idx_q == PUSH_LAST)
        begin
          pc_d = {ctx_q[7:0], STACK_DATA_IN};
          fresh_d = 1'b1;
          st_d = ST_RUN;
        end
      end
      ST_SLEEP:
      begin
        if (wake && halt_q)
          st_d = ST_DELAY; // Oscillator restarts, so the delay runs again.
        else if (wake)
          enter = 1'b1; // The waiting instruction has already completed.
      end
      default:
        st_d = ST_DELAY;
    endcase
    if (enter)
    begin
      st_d = ST_STACK;
      idx_d = '0;
      vec_d = sel_vec;
      ctx_d = {PROGRAM_COUNTER_IN[7:0], PROGRAM_COUNTER_IN[15:8], INDEX_IN, ACCUM_IN, CONDITION_CODE_IN};
      if (sel_vec == VEC_EXT)
        ext_pend_d = |((rise | fall) & en_q); // An edge in the entry cycle is kept, not lost.
    end
  end

  // Reset returns to the start delay; a watchdog reset does the same.
  always_ff @(posedge CLOCK)
  begin
    if (RESET || (CE && WATCHDOG_RESET))
    begin
      st_q <= ST_DELAY;
      cnt_q <= '0;
      en_q <= EDGE_EN_RESET;
      pin_q <= 8'h00;
      ext_pend_q <= 1'b0;
      per_pend_q <= 4'h0;
      mask_q <= 1'b1;
      halt_q <= 1'b0;
      idx_q <= '0;
      vec_q <= VEC_RESET;
      pc_q <= 16'h0000;
      ctx_q <= '0;
      lo_q <= 8'h00;
      fresh_q <= 1'b0;
    end
    else if (CE)
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      en_q <= en_d;
      pin_q <= pin_d;
      ext_pend_q <= ext_pend_d;
      per_pend_q <= per_pend_d;
      mask_q <= mask_d;
      halt_q <= halt_d;
      idx_q <= idx_d;
      vec_q <= vec_d;
      pc_q <= pc_d;
      ctx_q <= ctx_d;
      lo_q <= lo_d;
      fresh_q <= fresh_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------
  // Reset pin driven low while the watchdog fires; external reset is the far side's duty.
  assign RESET_PIN_OUT_N = 1'b0;
  assign RESET_PIN_OE_N = ~WATCHDOG_RESET;
  assign EXT_EDGE_ENABLE_Q = en_q;
  assign MASK = mask_q;
  assign CPU_HOLD = (st_q != ST_RUN);
  assign STACK_WRITE = (st_q == ST_STACK);
  assign STACK_READ = (st_q == ST_UNSTACK);
  assign STACK_DATA_OUT = ctx_q[39:32];
  assign STACK_INDEX = idx_q;
  assign VECTOR_READ = (st_q == ST_VECTOR);
  assign VECTOR_ADDR = {vec_q[15:1], idx_q[0]};
  assign PC_LOAD = fresh_q;
  assign PROGRAM_COUNTER_OUT = pc_q;
  assign RESTORED_CC = ctx_q[39:32];
  assign RESTORE_DONE = fresh_q;
  assign SLEEPING = (st_q == ST_SLEEP);

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  sequence entry_s;
    (st_q == ST_RUN) && INSTR_BOUNDARY && take && !RETURN_FROM_INTERRUPT_INSTR && CE;
  endsequence

  property entry_p;
    @(posedge CLOCK) disable iff (RESET || WATCHDOG_RESET) entry_s |=> STACK_WRITE;
  endproperty

  entry_stacks_a: assert property (entry_p) else $error("entry did not stack");
  mask_gate_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (st_q == ST_RUN) && mask_q && !TRAP_INSTR && CE |=> !STACK_WRITE) else $error("masked entry");
  mask_set_a: assert property (@(posedge CLOCK) disable iff (RESET || WATCHDOG_RESET)
    STACK_WRITE && idx_q == PUSH_LAST && CE |=> mask_q) else $error("mask not set");
  trap_vec_a: assert property (@(posedge CLOCK) disable iff (RESET || WATCHDOG_RESET)
    (st_q == ST_RUN) && INSTR_BOUNDARY && TRAP_INSTR && !RETURN_FROM_INTERRUPT_INSTR && CE
    |=> vec_q == VEC_TRAP) else $error("trap vector");
  reset_vec_a: assert property (@(posedge CLOCK)
    RESET |=> st_q == ST_DELAY && vec_q == VEC_RESET) else $error("reset vector");
  delay_hold_a: assert property (@(posedge CLOCK) disable iff (RESET)
    (st_q == ST_DELAY) && cnt_q != DELAY_LAST && CE |=> st_q == ST_DELAY) else $error("early release");
  edge_en_rst_a: assert property (@(posedge CLOCK)
    RESET |=> en_q == EDGE_EN_RESET) else $error("enable reset");
  wdg_pin_a: assert property (@(posedge CLOCK)
    WATCHDOG_RESET |-> !RESET_PIN_OE_N && !RESET_PIN_OUT_N) else $error("reset pin");
endmodule : irq_vec

// File: sim/irq_mem_model.sv
`timescale 1ns/1ns
module irq_mem_model
  import irq_vec_pkg::*;
(
  input wire logic CLOCK,
  input wire logic STACK_WRITE,
  input wire logic STACK_READ,
  input wire logic [7:0] STACK_DATA_OUT,
  input wire logic [2:0] STACK_INDEX,
  input wire logic VECTOR_READ,
  input wire logic [15:0] VECTOR_ADDR,
  output logic [7:0] STACK_DATA_IN
);
  logic [7:0] mem [0:7];
  logic [7:0] last_q = 8'h00;
  int writes = 0;
  // ---------------------------------------------------------------
  // Memory side of the core: vector table, stack and idle bus.
  // ---------------------------------------------------------------
  // Vector bytes are a scramble of the address so a swapped byte order shows up.
  // An idle bus shows the inverse of its last value, never a stale copy.
  always_comb
  begin
    if (VECTOR_READ)
      STACK_DATA_IN = VECTOR_ADDR[7:0] ^ 8'h3c;
    else if (STACK_READ)
      STACK_DATA_IN = mem[PUSH_LAST - STACK_INDEX]; // Pops come back in reverse push order.
    else
      STACK_DATA_IN = ~last_q;
  end
  // Stack writes land on the edge and are counted for the bench.
  always @(posedge CLOCK)
  begin
    last_q <= STACK_DATA_IN;
    if (STACK_WRITE)
    begin
      mem[STACK_INDEX] <= STACK_DATA_OUT;
      writes <= writes + 1;
    end
  end
endmodule : irq_mem_model

// File: sim/interrupt_and_reset_vectoring_tb.sv
`timescale 1ns/1ns
module interrupt_and_reset_vectoring_tb
  import irq_vec_pkg::*;
;
  localparam int DLY = 8;
  localparam logic [7:0] REST = FALL_LINES;
  typedef struct packed {logic [7:0] tog; logic [7:0] en; logic [3:0] fl; logic [15:0] vec;} row_t;
  logic CLOCK = 0, RESET = 1, WATCHDOG_RESET = 0, INSTR_BOUNDARY = 0, EXT_EDGE_ENABLE_WR = 0;
  logic TRAP_INSTR = 0, RETURN_FROM_INTERRUPT_INSTR = 0, WAIT_FOR_IRQ_INSTR = 0, HALT_INSTR = 0;
  logic SET_MASK = 0, CLEAR_MASK = 0;
  logic [7:0] EXT_IRQ_PIN = REST, EXT_EDGE_ENABLE_REG = 8'h00, STACK_DATA_IN, STACK_DATA_OUT;
  logic [3:0] PERIPH_FLAG = 4'h0, PERIPH_ENABLE = 4'h0, PERIPH_FLAG_CLEAR = 4'h0;
  logic RESET_PIN_OUT_N, RESET_PIN_OE_N, MASK, CPU_HOLD, STACK_WRITE, STACK_READ, VECTOR_READ;
  logic PC_LOAD, RESTORE_DONE, SLEEPING;
  logic [7:0] EXT_EDGE_ENABLE_Q, RESTORED_CC;
  logic [2:0] STACK_INDEX;
  logic [15:0] VECTOR_ADDR, PROGRAM_COUNTER_OUT;
  logic [39:0] ctx = {8'he1, 8'h78, 8'h56, 8'h12, 8'h34};
  int bad_count = 0, samples_checked = 0, cyc = 0;
  row_t rows [0:8] = '{'{8'h01, 8'h01, 4'h0, VEC_EXT}, '{8'h20, 8'h20, 4'h0, VEC_EXT},
    '{8'h04, 8'h04, 4'h0, VEC_EXT}, '{8'h80, 8'h80, 4'h0, VEC_EXT}, '{8'h00, 8'h00, 4'h1, VEC_FLASH},
    '{8'h00, 8'h00, 4'h4, VEC_TIMER}, '{8'h00, 8'h00, 4'h8, VEC_SERIAL},
    '{8'h00, 8'h00, 4'he, VEC_SUSPEND_END}, '{8'h10, 8'h10, 4'hc, VEC_EXT}};

  irq_vec #(.DELAY_CYCLES(DLY)) i_irq_vec (.CLOCK(CLOCK), .RESET(RESET), .CE(1'b1),
    .WATCHDOG_RESET(WATCHDOG_RESET), .RESET_PIN_OUT_N(RESET_PIN_OUT_N), .RESET_PIN_OE_N(RESET_PIN_OE_N),
    .EXT_IRQ_PIN(EXT_IRQ_PIN), .EXT_EDGE_ENABLE_REG(EXT_EDGE_ENABLE_REG), .EXT_EDGE_ENABLE_WR(EXT_EDGE_ENABLE_WR),
    .INSTR_BOUNDARY(INSTR_BOUNDARY), .TRAP_INSTR(TRAP_INSTR),
    .RETURN_FROM_INTERRUPT_INSTR(RETURN_FROM_INTERRUPT_INSTR), .WAIT_FOR_IRQ_INSTR(WAIT_FOR_IRQ_INSTR),
    .HALT_INSTR(HALT_INSTR), .SET_MASK(SET_MASK), .CLEAR_MASK(CLEAR_MASK), .CONDITION_CODE_IN(ctx[39:32]),
    .PROGRAM_COUNTER_IN(ctx[15:0]), .INDEX_IN(ctx[23:16]), .ACCUM_IN(ctx[31:24]),
    .STACK_DATA_IN(STACK_DATA_IN), .PERIPH_FLAG(PERIPH_FLAG), .PERIPH_ENABLE(PERIPH_ENABLE),
    .PERIPH_FLAG_CLEAR(PERIPH_FLAG_CLEAR), .EXT_EDGE_ENABLE_Q(EXT_EDGE_ENABLE_Q), .MASK(MASK),
    .CPU_HOLD(CPU_HOLD), .STACK_WRITE(STACK_WRITE), .STACK_READ(STACK_READ), .STACK_DATA_OUT(STACK_DATA_OUT),
    .STACK_INDEX(STACK_INDEX), .VECTOR_READ(VECTOR_READ), .VECTOR_ADDR(VECTOR_ADDR), .PC_LOAD(PC_LOAD),
    .PROGRAM_COUNTER_OUT(PROGRAM_COUNTER_OUT), .RESTORED_CC(RESTORED_CC), .RESTORE_DONE(RESTORE_DONE),
    .SLEEPING(SLEEPING));
  irq_mem_model i_irq_mem_model (.CLOCK(CLOCK), .STACK_WRITE(STACK_WRITE), .STACK_READ(STACK_READ),
    .STACK_DATA_OUT(STACK_DATA_OUT), .STACK_INDEX(STACK_INDEX), .VECTOR_READ(VECTOR_READ),
    .VECTOR_ADDR(VECTOR_ADDR), .STACK_DATA_IN(STACK_DATA_IN));

  // ---------------------------------------------------------------
  // Clock, timeout and shared tasks.
  // ---------------------------------------------------------------
  always #4 CLOCK = ~CLOCK;
  // The limit is far above the few hundred cycles the sequence needs.
  always @(posedge CLOCK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      final_report();
    end
  end
  function automatic logic [15:0] vpair(input logic [15:0] v);
    return {v[7:0] ^ 8'h3c, (v[7:0] | 8'h01) ^ 8'h3c};
  endfunction : vpair
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  // One boundary pulse; k is one-hot {halt, wait, return, trap}.
  task automatic step(input logic [3:0] k);
    @(posedge CLOCK);
    INSTR_BOUNDARY <= 1'b1;
    {HALT_INSTR, WAIT_FOR_IRQ_INSTR, RETURN_FROM_INTERRUPT_INSTR, TRAP_INSTR} <= k;
    @(posedge CLOCK);
    INSTR_BOUNDARY <= 1'b0;
    {HALT_INSTR, WAIT_FOR_IRQ_INSTR, RETURN_FROM_INTERRUPT_INSTR, TRAP_INSTR} <= 4'h0;
  endtask : step
  task automatic mask_op(input logic s, input logic c);
    @(posedge CLOCK);
    {SET_MASK, CLEAR_MASK} <= {s, c};
    @(posedge CLOCK);
    {SET_MASK, CLEAR_MASK} <= 2'b00;
  endtask : mask_op
  task automatic pins(input logic [7:0] en, input logic [7:0] tog);
    @(posedge CLOCK);
    EXT_EDGE_ENABLE_REG <= en;
    EXT_EDGE_ENABLE_WR <= 1'b1;
    @(posedge CLOCK);
    EXT_EDGE_ENABLE_WR <= 1'b0;
    EXT_IRQ_PIN <= REST ^ tog;
  endtask : pins
  // Flags and enables stay as levels; the clear sequence is a one-cycle pulse.
  task automatic periph(input logic [3:0] fl, input logic [3:0] en, input logic [3:0] clr);
    @(posedge CLOCK);
    PERIPH_FLAG <= fl;
    PERIPH_ENABLE <= en;
    PERIPH_FLAG_CLEAR <= clr;
    @(posedge CLOCK);
    PERIPH_FLAG_CLEAR <= 4'h0;
  endtask : periph
  task automatic serve(input logic [15:0] v);
    int n;
    n = 0;
    while (STACK_WRITE !== 1'b1 && n < 40) begin @(negedge CLOCK); n++; end
    while (CPU_HOLD !== 1'b0 && n < 60) begin @(negedge CLOCK); n++; end
    check("entry_wait", n < 60, 1'b1);
    check("vector_target", PROGRAM_COUNTER_OUT, vpair(v));
    check("mask_on_entry", MASK, 1'b1);
    for (int i = 0; i < 5; i++) check("stacked", i_irq_mem_model.mem[i], ctx[8*i+:8]);
  endtask : serve
  task automatic ret();
    int n;
    n = 0;
    step(4'h2);
    while (RESTORE_DONE !== 1'b1 && n < 20) begin @(negedge CLOCK); n++; end
    check("restored_flags", RESTORED_CC, ctx[39:32]);
    check("pc_load", PC_LOAD, 1'b1);
    while (CPU_HOLD !== 1'b0 && n < 30) begin @(negedge CLOCK); n++; end
    check("resume_counter", PROGRAM_COUNTER_OUT, ctx[15:0]);
    check("mask_after_return", MASK, 1'b0);
  endtask : ret
  // A boundary that must not start an entry.
  task automatic quiet();
    int w;
    w = i_irq_mem_model.writes;
    step(4'h0);
    repeat (6) @(negedge CLOCK);
    check("no_entry", i_irq_mem_model.writes, w);
  endtask : quiet
  task automatic boot();
    int n;
    n = 0;
    while (CPU_HOLD !== 1'b0 && n < 40) begin @(negedge CLOCK); n++; end
    check("start_delay", n >= DLY && n < 40, 1'b1);
    check("reset_target", PROGRAM_COUNTER_OUT, vpair(VEC_RESET));
  endtask : boot

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge CLOCK);
    RESET <= 1'b0;
    @(negedge CLOCK);
    check("mask_reset", MASK, 1'b1);
    check("edge_en_reset", EXT_EDGE_ENABLE_Q, EDGE_EN_RESET);
    check("pin_oe_idle", RESET_PIN_OE_N, 1'b1);
    boot();
    mask_op(1'b0, 1'b1);
    foreach (rows[i])
    begin
      pins(rows[i].en, rows[i].tog);
      periph(rows[i].fl, rows[i].fl, 4'h0);
      step(4'h0);
      serve(rows[i].vec);
      check("edge_en", EXT_EDGE_ENABLE_Q, rows[i].en);
      pins(rows[i].en, 8'h00);
      periph(4'h0, 4'h0, rows[i].fl);
      ret();
      quiet();
    end
    mask_op(1'b1, 1'b0);
    periph(4'h8, 4'h8, 4'h0);
    quiet();
    mask_op(1'b0, 1'b1);
    repeat (3) @(negedge CLOCK);
    check("hold_until_boundary", CPU_HOLD, 1'b0);
    step(4'h0);
    serve(VEC_SERIAL);
    periph(4'h0, 4'h0, 4'h8);
    ret();
    periph(4'h4, 4'h0, 4'h0);
    quiet();
    periph(4'h0, 4'h0, 4'h4);
    periph(4'h0, 4'h4, 4'h0);
    quiet();
    pins(8'h00, 8'h02);
    quiet();
    pins(8'h00, 8'h00);
    mask_op(1'b1, 1'b0);
    step(4'h1);
    serve(VEC_TRAP);
    ret();
    step(4'h4);
    @(negedge CLOCK);
    check("asleep_wait", SLEEPING, 1'b1);
    periph(4'h4, 4'h4, 4'h0);
    serve(VEC_TIMER);
    periph(4'h0, 4'h0, 4'h4);
    ret();
    pins(8'h01, 8'h00);
    step(4'h8);
    periph(4'h4, 4'h4, 4'h0);
    repeat (6) @(negedge CLOCK);
    check("asleep_halt", SLEEPING, 1'b1);
    pins(8'h01, 8'h01);
    serve(VEC_EXT);
    periph(4'h0, 4'h0, 4'h4);
    pins(8'h01, 8'h00);
    ret();
    @(posedge CLOCK);
    WATCHDOG_RESET <= 1'b1;
    @(negedge CLOCK);
    check("pin_oe_wdog", RESET_PIN_OE_N, 1'b0);
    check("pin_level_wdog", RESET_PIN_OUT_N, 1'b0);
    @(posedge CLOCK);
    WATCHDOG_RESET <= 1'b0;
    @(negedge CLOCK);
    check("pin_oe_release", RESET_PIN_OE_N, 1'b1);
    boot();
    final_report();
  end
endmodule : interrupt_and_reset_vectoring_tb
